// *** src/ctc_channel.v ***
// counter/totalize channel: count, latch into scan stream, software reads
`timescale 1ns/1ps
`include "ctc_consts.vh"
module ctc_channel #(
  parameter CHAN_IDX = 0
) (
  // clock and reset
  input wire i_mclk,
  input wire i_resetn,
  // debounced, edge-selected counter inputs and all read strobes
  input wire [`CTC_NUM_CHAN-1:0] i_chan_in,
  input wire [`CTC_NUM_CHAN-1:0] i_read_strobes,
  // mode and options
  input wire [`CTC_MODE_W-1:0] i_mode,
  input wire i_clear_on_read_select,
  input wire i_saturate_select,
  input wire i_wide_count_select,
  input wire i_latch_source_select,
  input wire i_mapped_gate_enable,
  input wire i_mapped_decrement_enable,
  input wire i_mapped_increment_enable,
  input wire [1:0] i_averaging_or_decode_field,
  input wire [`CTC_SEL_W-1:0] i_map_sel,
  input wire i_upper_only,
  // scan sequencer
  input wire i_start_of_scan,
  input wire i_first_scan,
  input wire i_in_scan,
  input wire i_slot_take,
  input wire i_slot_upper,
  // software reads
  input wire i_sw_read_lo,
  input wire i_sw_read_hi,
  // scan stream
  output reg [`CTC_HALF_W-1:0] o_slot_data,
  output reg o_slot_valid,
  output reg [1:0] o_slots_per_sample,
  // software read data and this channel's read strobe
  output reg [`CTC_HALF_W-1:0] o_sw_data,
  output reg o_sw_valid,
  output reg o_read_strobe,
  // state
  output reg [`CTC_CNT_W-1:0] o_count,
  output reg [`CTC_CNT_W-1:0] o_latched,
  // option decodes for the other modes
  output reg [9:0] o_periods_per_meas,
  output reg [2:0] o_decode_mult,
  output reg o_measure_mapped
);

  ////////////////////////////////////////////////////////////////////////
  // source edges and mapped-channel selection

  wire [`CTC_SRC_W-1:0] src_level;
  wire [`CTC_SRC_W-1:0] src_rise;

  ctc_src_edge #(
    .SRC_W(`CTC_SRC_W)
  ) u_src_edge (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_src({i_read_strobes, i_chan_in}),
    .o_level(src_level),
    .o_rise(src_rise)
  );

  wire own_rise;
  wire map_level;
  wire map_rise;

  // low four selects are inputs, upper four are read strobes
  assign own_rise = src_rise[CHAN_IDX];
  assign map_level = src_level[i_map_sel];
  assign map_rise = src_rise[i_map_sel];

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  wire mode_counter;
  wire mode_encoder;
  wire mode_pulsewidth;

  assign mode_counter = (i_mode == `CTC_MODE_COUNTER);
  assign mode_encoder = (i_mode == `CTC_MODE_ENCODER);
  assign mode_pulsewidth = (i_mode == `CTC_MODE_PULSEWIDTH);

  ////////////////////////////////////////////////////////////////////////
  // count events

  wire gate_open;
  wire inc_src;
  wire inc_ev;
  wire dec_ev;

  // gated counter holds while the mapped channel is low
  assign gate_open = ~i_mapped_gate_enable | map_level;
  // a mapped edge takes the place of the own edge, never both
  assign inc_src = i_mapped_increment_enable ? map_rise : own_rise;
  assign inc_ev = mode_counter & gate_open & inc_src;
  assign dec_ev = mode_counter & gate_open &
                  i_mapped_decrement_enable & map_rise;

  ////////////////////////////////////////////////////////////////////////
  // latch and clear events

  wire sw_read_ok;
  wire scan_latch;
  wire sw_latch;
  wire sw_hi_read;
  wire latch_now;
  wire clr_on_latch;
  wire index_clear;
  wire any_clear;

  // async reads only in counter and encoder modes, and not during a scan
  assign sw_read_ok = (mode_counter | mode_encoder) & ~i_in_scan;
  assign sw_latch = i_sw_read_lo & sw_read_ok;
  assign sw_hi_read = i_sw_read_hi & sw_read_ok;
  assign scan_latch = i_latch_source_select ? map_rise : i_start_of_scan;
  assign latch_now = scan_latch | sw_latch;
  assign clr_on_latch = i_clear_on_read_select & latch_now;
  assign index_clear = mode_encoder & i_mapped_decrement_enable & map_rise;
  // clear-on-read and the index both zero the count
  assign any_clear = clr_on_latch | index_clear;

  ////////////////////////////////////////////////////////////////////////
  // counter next value

  reg [`CTC_CNT_W-1:0] count_q;
  reg [`CTC_CNT_W-1:0] count_d;
  reg [`CTC_CNT_W-1:0] top;
  reg at_top;
  reg at_zero;
  wire [`CTC_CNT_W-1:0] count_plus;
  wire [`CTC_CNT_W-1:0] count_minus;

  // one adder each way; no wider result ever needs cutting back
  assign count_plus = count_q + 32'h00000001;
  assign count_minus = count_q - 32'h00000001;

  always @* begin
    // width only moves the saturation point
    top = i_wide_count_select ? `CTC_TOP_WIDE : `CTC_TOP_NARROW;
    at_top = (count_q >= top);
    at_zero = (count_q == {`CTC_CNT_W{1'b0}});
    count_d = count_q;
    if (i_first_scan) begin
      count_d = {`CTC_CNT_W{1'b0}};
    end else if (any_clear) begin
      // an edge in the clear cycle opens the next interval
      count_d = (inc_ev & ~dec_ev) ? 32'h00000001 : 32'h00000000;
    end else if (inc_ev & dec_ev) begin
      count_d = count_q;
    end else if (inc_ev) begin
      if (i_saturate_select & at_top) begin
        count_d = count_q;
      end else begin
        // wrap at 32 bits; the low half wraps at 16 on its own
        count_d = count_plus;
      end
    end else if (dec_ev) begin
      if (i_saturate_select & at_zero) begin
        count_d = count_q;
      end else begin
        count_d = count_minus;
      end
    end
  end

  always @(posedge i_mclk) begin
    if (!i_resetn) begin
      count_q <= 32'h00000000;
    end else begin
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scan latch and slot output

  reg [`CTC_CNT_W-1:0] latch_q;
  reg [`CTC_CNT_W-1:0] latch_d;
  wire [`CTC_HALF_W-1:0] slot_word;
  wire wide_sample;

  assign slot_word = i_slot_upper ? latch_q[31:16] : latch_q[15:0];
  // a full 32-bit result costs a second slot, halving the sample rate
  assign wide_sample = i_wide_count_select & ~i_upper_only;

  always @* begin
    latch_d = latch_q;
    if (i_first_scan) begin
      latch_d = 32'h00000000;
    end else if (latch_now) begin
      // value just before a clear-on-read or index clear is kept; a first scan loads zero instead
      latch_d = count_q;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_resetn) begin
      latch_q <= 32'h00000000;
      o_slot_data <= 16'h0000;
      o_slot_valid <= 1'b0;
      o_slots_per_sample <= `CTC_SLOTS_NARROW;
    end else begin
      latch_q <= latch_d;
      o_slot_valid <= i_slot_take;
      if (i_slot_take) begin
        // upper-only sampling keeps the full slot rate
        o_slot_data <= slot_word;
      end
      if (wide_sample) begin
        o_slots_per_sample <= `CTC_SLOTS_WIDE;
      end else begin
        o_slots_per_sample <= `CTC_SLOTS_NARROW;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software reads

  reg [`CTC_CNT_W-1:0] sw_cap_q;

  always @(posedge i_mclk) begin
    if (!i_resetn) begin
      sw_cap_q <= 32'h00000000;
      o_sw_data <= 16'h0000;
      o_sw_valid <= 1'b0;
      o_read_strobe <= 1'b0;
    end else begin
      // low read strobes and captures the whole value
      o_read_strobe <= sw_latch;
      o_sw_valid <= sw_latch | sw_hi_read;
      if (sw_latch) begin
        sw_cap_q <= count_q;
        o_sw_data <= count_q[15:0];
      end else if (sw_hi_read) begin
        // high half comes from the earlier capture, not the live count
        o_sw_data <= sw_cap_q[31:16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state outputs

  always @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_count <= 32'h00000000;
      o_latched <= 32'h00000000;
    end else begin
      // mirrors the next value so it lines up with the internal count
      o_count <= count_d;
      o_latched <= latch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // option decodes for period, encoder and pulsewidth modes

  reg [9:0] periods_d;
  reg [2:0] mult_d;

  // decoded every cycle whatever the mode, so a mode change needs no settling time
  always @* begin
    case (i_averaging_or_decode_field)
      2'h0: begin
        periods_d = `CTC_AVG_1;
      end
      2'h1: begin
        periods_d = `CTC_AVG_10;
      end
      2'h2: begin
        periods_d = `CTC_AVG_100;
      end
      default: begin
        periods_d = `CTC_AVG_1000;
      end
    endcase
    case (i_averaging_or_decode_field)
      2'h1: begin
        mult_d = `CTC_DEC_2X;
      end
      2'h2: begin
        mult_d = `CTC_DEC_4X;
      end
      default: begin
        // unused code falls back to single edge decoding
        mult_d = `CTC_DEC_1X;
      end
    endcase
  end

  always @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_periods_per_meas <= `CTC_AVG_1;
      o_decode_mult <= `CTC_DEC_1X;
      o_measure_mapped <= 1'b0;
    end else begin
      o_periods_per_meas <= periods_d;
      o_decode_mult <= mult_d;
      o_measure_mapped <= mode_pulsewidth & i_mapped_increment_enable;
    end
  end

endmodule

// *** src/ctc_consts.vh ***
// constants for the counter/totalize channel
`ifndef CTC_CONSTS_VH
`define CTC_CONSTS_VH

`define CTC_CNT_W 32
`define CTC_HALF_W 16
`define CTC_NUM_CHAN 4
`define CTC_SRC_W 8
`define CTC_SEL_W 3

`define CTC_TOP_NARROW 32'h0000ffff
`define CTC_TOP_WIDE 32'hffffffff

`define CTC_MODE_W 3
`define CTC_MODE_COUNTER 3'h0
`define CTC_MODE_PERIOD 3'h1
`define CTC_MODE_PULSEWIDTH 3'h2
`define CTC_MODE_TIMING 3'h3
`define CTC_MODE_ENCODER 3'h4

`define CTC_AVG_1 10'h001
`define CTC_AVG_10 10'h00a
`define CTC_AVG_100 10'h064
`define CTC_AVG_1000 10'h3e8

`define CTC_DEC_1X 3'h1
`define CTC_DEC_2X 3'h2
`define CTC_DEC_4X 3'h4

`define CTC_SLOT_RATE_HZ 12000000
`define CTC_SLOTS_NARROW 2'h1
`define CTC_SLOTS_WIDE 2'h2

`endif

// *** src/ctc_src_edge.v ***
// registers the eight mapped-channel sources and finds their rising edges
`timescale 1ns/1ps
module ctc_src_edge #(
  parameter SRC_W = 8
) (
  // clock and reset
  input wire i_mclk,
  input wire i_resetn,
  // sources
  input wire [SRC_W-1:0] i_src,
  // registered level and one-cycle rising edge
  output wire [SRC_W-1:0] o_level,
  output wire [SRC_W-1:0] o_rise
);

  reg [SRC_W-1:0] cur_q;
  reg [SRC_W-1:0] prev_q;

  genvar g;
  generate
    for (g = 0; g < SRC_W; g = g + 1) begin : g_src
      always @(posedge i_mclk) begin
        if (!i_resetn) begin
          cur_q[g] <= 1'b0;
          prev_q[g] <= 1'b0;
        end else begin
          cur_q[g] <= i_src[g];
          prev_q[g] <= cur_q[g];
        end
      end
      // one rising edge gives exactly one pulse
      assign o_rise[g] = cur_q[g] & ~prev_q[g];
    end
  endgenerate

  assign o_level = cur_q;

endmodule

// *** testbench/ctc_channel_chk.sv ***
// assertion checker for the counter channel ports
`timescale 1ns/1ps
module ctc_channel_chk (
  // clock and reset
  input wire i_mclk,
  input wire i_resetn,
  // controls
  input wire [2:0] i_mode,
  input wire i_saturate_select,
  input wire i_wide_count_select,
  input wire i_latch_source_select,
  input wire i_mapped_decrement_enable,
  input wire i_clear_on_read_select,
  input wire i_upper_only,
  input wire i_start_of_scan,
  input wire i_first_scan,
  input wire i_in_scan,
  input wire i_slot_take,
  input wire i_slot_upper,
  input wire i_sw_read_lo,
  // outputs
  input wire [15:0] o_slot_data,
  input wire o_slot_valid,
  input wire [1:0] o_slots_per_sample,
  input wire [15:0] o_sw_data,
  input wire o_sw_valid,
  input wire o_read_strobe,
  input wire [31:0] o_count,
  input wire [31:0] o_latched
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  ////////////////
  wire ok = i_sw_read_lo && !i_in_scan && (i_mode == 3'h0 || i_mode == 3'h4);
  wire [15:0] c_lo = o_count[15:0];
  wire [15:0] l_lo = o_latched[15:0];
  wire [15:0] l_hi = o_latched[31:16];
  wire [31:0] top = i_wide_count_select ? 32'hffffffff : 32'h0000ffff;
  wire hold = i_saturate_select && !i_mapped_decrement_enable && !i_clear_on_read_select;
  ////////////////
  a_sw_strobe: assert property (ok |=> o_read_strobe && o_sw_valid)
    else $error("read strobe missing");
  a_sw_refused: assert property (!ok |=> !o_read_strobe)
    else $error("read strobe not refused");
  a_sw_low_data: assert property (ok |=> o_sw_data == $past(c_lo))
    else $error("low read data wrong");
  a_first_clear: assert property (i_first_scan |=> o_latched == 32'h0)
    else $error("first scan left latch");
  a_scan_latch: assert property (i_start_of_scan && !i_first_scan && !i_latch_source_select
    |=> o_latched == $past(o_count))
    else $error("scan latch wrong");
  a_slot_word: assert property (i_slot_take |=> o_slot_valid
    && o_slot_data == ($past(i_slot_upper) ? $past(l_hi) : $past(l_lo)))
    else $error("slot word wrong");
  a_slot_count: assert property ($past(i_resetn) |-> o_slots_per_sample ==
    (($past(i_wide_count_select) && !$past(i_upper_only)) ? 2'h2 : 2'h1))
    else $error("slot count wrong");
  a_sat_hold: assert property (hold && !i_first_scan && o_count == top
    |=> o_count == $past(o_count))
    else $error("saturated count moved");
  a_one_step: assert property (o_count <= 32'h1 || o_count == $past(o_count)
    || o_count == $past(o_count) + 32'h1 || o_count == $past(o_count) - 32'h1)
    else $error("count jumped");
  c_sw: cover property (ok ##1 o_sw_valid);
  c_upper: cover property (i_slot_take && i_slot_upper);
  c_sat: cover property (hold && o_count == top);
endmodule
bind ctc_channel ctc_channel_chk u_chk (.*);

// *** testbench/ctc_scan_seq.sv ***
// scan sequencer model: start of scan, first scan, two slot takes
`timescale 1ns/1ps
module ctc_scan_seq (
  // clock and request
  input wire i_mclk,
  input wire i_go,
  input wire i_first,
  // scan controls
  output reg o_sos = 1'h0,
  output reg o_first_scan = 1'h0,
  output reg o_take = 1'h0,
  output reg o_upper = 1'h0
);
  reg [2:0] st_q = 3'h0;
  // step on rising edge, drive on falling edge, away from the sampling edge
  always @(posedge i_mclk) begin
    st_q <= i_go ? 3'h1 : (st_q == 3'h0 || st_q == 3'h5) ? 3'h0 : st_q + 3'h1;
  end
  always @(negedge i_mclk) begin
    o_sos <= st_q == 3'h1;
    o_first_scan <= st_q == 3'h1 && i_first;
    o_take <= st_q == 3'h3 || st_q == 3'h4;
    o_upper <= st_q == 3'h4;
  end
endmodule

// *** testbench/test_ctc_channel.sv ***
// self-checking bench for the counter channel
`timescale 1ns/1ps
module test_ctc_channel;
  reg i_mclk = 1'h0;
  reg i_resetn = 1'h0;
  reg [3:0] i_chan_in, i_read_strobes, g;
  reg [2:0] i_mode, i_map_sel;
  reg [1:0] i_averaging_or_decode_field;
  reg i_clear_on_read_select, i_saturate_select, i_wide_count_select, i_latch_source_select;
  reg i_mapped_gate_enable, i_mapped_decrement_enable, i_mapped_increment_enable;
  reg i_upper_only, i_in_scan, i_sw_read_lo, i_sw_read_hi, go, fsr;
  wire i_start_of_scan, i_first_scan, i_slot_take, i_slot_upper;
  wire [15:0] o_slot_data, o_sw_data;
  wire o_slot_valid, o_sw_valid, o_read_strobe, o_measure_mapped;
  wire [1:0] o_slots_per_sample;
  wire [31:0] o_count, o_latched;
  wire [9:0] o_periods_per_meas;
  wire [2:0] o_decode_mult;
  logic [15:0] q[$];
  logic [31:0] e;
  logic [9:0] pv[4] = '{10'h1, 10'ha, 10'h64, 10'h3e8};
  logic [2:0] dv[4] = '{3'h1, 3'h2, 3'h4, 3'h1};
  int failures = 0;
  int checks = 0;
  int n;
  ////////////////
  ctc_channel u_dut (.*);
  ctc_scan_seq u_seq (.i_mclk, .i_go(go), .i_first(fsr), .o_sos(i_start_of_scan),
    .o_first_scan(i_first_scan), .o_take(i_slot_take), .o_upper(i_slot_upper));
  always #5 i_mclk = ~i_mclk;
  ////////////////
  task chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      failures++;
      $display("ERROR %0t seen %h want %h", $time, s, x);
    end
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task idle(input int c);
    repeat (c) @(negedge i_mclk);
  endtask
  // one-cycle pulse on chosen sources; gap leaves room for the two-edge pipeline
  task pu(input logic [7:0] m);
    @(negedge i_mclk) {i_read_strobes, i_chan_in} = m | g;
    @(negedge i_mclk) {i_read_strobes, i_chan_in} = {4'h0, g};
    idle(3);
  endtask
  task rd(input logic ok);
    if (ok) q.push_back(e[15:0]);
    if (ok) q.push_back(e[31:16]);
    @(negedge i_mclk) i_sw_read_lo = 1'h1;
    @(negedge i_mclk) i_sw_read_lo = 1'h0;
    @(negedge i_mclk) i_sw_read_hi = 1'h1;
    @(negedge i_mclk) i_sw_read_hi = 1'h0;
    idle(2);
  endtask
  task scan(input logic f);
    q.push_back(e[15:0]);
    q.push_back(e[31:16]);
    fsr = f;
    @(negedge i_mclk) go = 1'h1;
    @(negedge i_mclk) go = 1'h0;
    idle(8);
  endtask
  ////////////////
  always @(posedge i_mclk) begin
    #1;
    if (o_slot_valid === 1'h1 || o_sw_valid === 1'h1)
      chk(o_slot_valid ? o_slot_data : o_sw_data, q.size() ? q.pop_front() : 'x);
  end
  initial begin
    #100000;
    failures++;
    end_of_test;
  end
  initial begin
    {i_chan_in, i_read_strobes, g, i_mode, i_map_sel, i_averaging_or_decode_field} = 20'h0;
    {i_clear_on_read_select, i_saturate_select, i_wide_count_select, i_latch_source_select,
      i_mapped_gate_enable, i_mapped_decrement_enable, i_mapped_increment_enable,
      i_upper_only, i_in_scan, i_sw_read_lo, i_sw_read_hi, go, fsr} = 13'h0;
    n = $urandom(32'ha564f21b);
    idle(16);
    i_resetn = 1'h1;
    n = $urandom_range(20, 3);
    repeat (n) pu(8'h1);
    e = n;
    chk(o_count, e);
    rd(1'h1);
    i_clear_on_read_select = 1'h1;
    repeat (3) pu(8'h1);
    e = e + 32'h3;
    rd(1'h1);
    e = 32'h0;
    chk(o_count, e);
    {i_clear_on_read_select, i_mapped_decrement_enable, i_map_sel} = 5'h9;
    pu(8'h3);
    chk(o_count, e);
    pu(8'h2);
    e = 32'hffffffff;
    chk(o_count, e);
    {i_saturate_select, i_wide_count_select, i_mapped_decrement_enable} = 3'h6;
    pu(8'h1);
    chk(o_count, e);
    rd(1'h1);
    {i_saturate_select, i_wide_count_select, i_mapped_decrement_enable} = 3'h0;
    pu(8'h1);
    e = 32'h0;
    chk(o_count, e);
    {i_mapped_gate_enable, i_map_sel} = 4'ha;
    pu(8'h1);
    chk(o_count, e);
    g = 4'h4;
    i_chan_in = g;
    pu(8'h1);
    e = e + 32'h1;
    chk(o_count, e);
    g = 4'h0;
    {i_mapped_gate_enable, i_mapped_increment_enable, i_map_sel} = 5'hb;
    pu(8'h1);
    pu(8'h8);
    e = e + 32'h1;
    chk(o_count, e);
    i_mapped_increment_enable = 1'h0;
    for (n = 0; n < 5; n++) begin
      i_mode = n[2:0];
      idle(2);
      rd(n == 0 || n == 4);
    end
    {i_mode, i_mapped_increment_enable} = 4'h5;
    idle(2);
    chk(o_measure_mapped, 1'h1);
    {i_mode, i_mapped_increment_enable, i_mapped_decrement_enable, i_map_sel} = 8'h89;
    pu(8'h2);
    e = 32'h0;
    chk(o_count, e);
    chk(o_measure_mapped, 1'h0);
    {i_mode, i_mapped_decrement_enable} = 4'h0;
    for (n = 0; n < 4; n++) begin
      i_averaging_or_decode_field = n[1:0];
      idle(2);
      chk(o_periods_per_meas, pv[n]);
      chk(o_decode_mult, dv[n]);
    end
    i_latch_source_select = 1'h1;
    for (n = 1; n < 8; n++) begin
      i_map_sel = n[2:0];
      pu(8'h1);
      e = e + 32'h1;
      pu(8'h1 << n);
      chk(o_latched, e);
    end
    {i_latch_source_select, i_in_scan, i_wide_count_select} = 3'h3;
    idle(2);
    chk(o_slots_per_sample, 2'h2);
    i_upper_only = 1'h1;
    idle(2);
    chk(o_slots_per_sample, 2'h1);
    i_upper_only = 1'h0;
    rd(1'h0);
    scan(1'h0);
    e = 32'h0;
    scan(1'h1);
    chk(o_count, e);
    n = $urandom_range(9, 2);
    repeat (n) pu(8'h1);
    e = n;
    i_clear_on_read_select = 1'h1;
    scan(1'h0);
    e = 32'h0;
    chk(o_count, e);
    end_of_test;
  end
endmodule
